// ### common/ppe_params.svh
`ifndef PPE_PARAMS_SVH
`define PPE_PARAMS_SVH

`define PPE_ADDR_W 4
`define PPE_DATA_W 32

// register offsets (byte addresses, word aligned)
`define PPE_OFF_PMCS 4'h0
`define PPE_OFF_PMC 4'h4
`define PPE_OFF_INTCTL 4'h8
`define PPE_OFF_MISC2 4'hC

// control/status fields
`define PPE_PMCS_PSTATE_LSB 0
`define PPE_PMCS_EN_BIT 8
`define PPE_PMCS_ST_BIT 15
`define PPE_PMC_SUP_LSB 27
`define PPE_INTCTL_PSC_BIT 0
`define PPE_INTCTL_IRQ_BIT 16
`define PPE_MISC2_RST_BIT 0
`define PPE_MISC2_I2E_BIT 1
`define PPE_MISC2_LOAD_BIT 2
`define PPE_SUP_D0_BIT 0
`define PPE_SUP_D3_BIT 3

`define PPE_D0 2'h0
`define PPE_D3HOT 2'h3

// local reset pulse: 512..1024 pci clocks
`define PPE_PCI_CLK_NS 30
`define PPE_LRST_MIN_PCI 512
`define PPE_LRST_MAX_PCI 1024
`define PPE_SYS_CLK_NS 5
`define PPE_LRST_CYC_DEF 3072
`define PPE_CNT_W 14

`endif

// ### common/ppe_pkg.sv
package ppe_pkg;

  typedef enum logic [1:0] {
    PPE_IDLE,
    PPE_RESET,
    PPE_LOAD
  } ppe_seq_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ppe_bus_t;

  typedef struct packed {
    logic [1:0] pstate;
    logic ev_en;
    logic ev_st;
  } ppe_pm_t;

endpackage

// ### rtl/ppe_sync.sv
`timescale 1ns/1ps
module ppe_sync (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;

  // first stage feeds only the second
  // resets to the idle level of the active-low pin, else a false edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= 1'b1;
      o_q <= 1'b1;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule

// ### rtl/ppe_event_top.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ppe_params.svh"
module ppe_event_top #(
  parameter int LRST_CYC = `PPE_LRST_CYC_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire ppe_pkg::ppe_bus_t i_lbus,
  input wire logic i_pci_ps_wr,
  input wire logic [1:0] i_pci_ps_wdata,
  input wire logic i_pci_clr_st,
  input wire logic i_pci_en_wr,
  input wire logic i_pci_en_wdata,
  input wire logic i_load_valid,
  input wire logic [31:0] i_load_pmc,
  input wire logic [31:0] i_load_misc2,
  input wire logic i_local_irq_n,
  output logic [31:0] o_rdata,
  output logic o_pm_event_out,
  output logic o_pm_event_oe,
  output logic o_local_irq_out,
  output logic o_local_irq_oe,
  output logic o_local_bus_reset_out_n,
  output logic o_int_reset,
  output logic o_load_req,
  output ppe_pkg::ppe_pm_t o_pm
);
  import ppe_pkg::*;

  localparam int LRST_MIN_CYC =
    (`PPE_LRST_MIN_PCI * `PPE_PCI_CLK_NS + `PPE_SYS_CLK_NS - 1)
    / `PPE_SYS_CLK_NS;
  localparam int LRST_MAX_CYC =
    (`PPE_LRST_MAX_PCI * `PPE_PCI_CLK_NS) / `PPE_SYS_CLK_NS;
  localparam logic [`PPE_CNT_W-1:0] LRST_LAST =
    `PPE_CNT_W'(LRST_CYC - 1);

  logic rst_meta_reg;
  logic rst_n_reg;
  logic irq_n_sync;
  logic irq_prev_reg;
  logic [1:0] pstate_reg;
  logic ev_en_reg;
  logic ev_st_reg;
  logic [3:0] sup_reg;
  logic state_change_irq_enable_reg;
  logic psc_irq_reg;
  logic psc_rst_reg;
  logic i2e_reg;
  logic load_en_reg;
  ppe_seq_t seq_reg;
  logic [`PPE_CNT_W-1:0] cnt_reg;
  logic lw;
  logic lw_pmcs;
  logic [1:0] l_ps;
  logic l_to_d3;
  logic l_to_d0;
  logic p_to_d3;
  logic p_to_d0;
  logic irq_rise;
  logic set_st;
  logic int_rst;

  function automatic logic is_wr(input ppe_bus_t b, input logic [3:0] off);
    is_wr = b.wr && (b.addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  ppe_sync u_irq_sync (
    .i_clk(i_sys_clk),
    .i_rstn(rst_n_reg),
    .i_d(i_local_irq_n),
    .o_q(irq_n_sync)
  );

  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_prev_reg <= 1'b1;
    end else begin
      irq_prev_reg <= irq_n_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transition decode

  assign lw = i_lbus.wr;
  assign lw_pmcs = is_wr(i_lbus, `PPE_OFF_PMCS);
  assign l_ps = i_lbus.wdata[`PPE_PMCS_PSTATE_LSB +: 2];
  assign l_to_d3 = lw_pmcs && pstate_reg == `PPE_D0 && l_ps == `PPE_D3HOT;
  assign l_to_d0 = lw_pmcs && pstate_reg != `PPE_D0 && l_ps == `PPE_D0;
  assign p_to_d3 = i_pci_ps_wr && pstate_reg == `PPE_D0 &&
                   i_pci_ps_wdata == `PPE_D3HOT;
  assign p_to_d0 = i_pci_ps_wr && pstate_reg == `PPE_D3HOT &&
                   i_pci_ps_wdata == `PPE_D0;
  assign irq_rise = irq_prev_reg && !irq_n_sync;
  assign int_rst = (seq_reg == PPE_RESET);

  always_comb begin
    set_st = 1'b0;
    if (l_to_d3 && sup_reg[`PPE_SUP_D3_BIT]) begin
      set_st = 1'b1;
    end else if (l_to_d0 && sup_reg[`PPE_SUP_D0_BIT]) begin
      set_st = 1'b1;
    end
    if (irq_rise && pstate_reg == `PPE_D3HOT && i2e_reg &&
        sup_reg[`PPE_SUP_D3_BIT] && ev_en_reg) begin
      set_st = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state field, both hosts may write it

  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pstate_reg <= `PPE_D0;
    end else if (int_rst) begin
      pstate_reg <= `PPE_D0;
    end else if (i_pci_ps_wr) begin
      pstate_reg <= i_pci_ps_wdata;
    end else if (lw_pmcs) begin
      pstate_reg <= l_ps;
    end
  end

  // event enable and sticky status; a set beats a clear
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ev_en_reg <= 1'b0;
      ev_st_reg <= 1'b0;
    end else begin
      if (i_pci_en_wr) begin
        ev_en_reg <= i_pci_en_wdata;
      end else if (lw_pmcs) begin
        ev_en_reg <= i_lbus.wdata[`PPE_PMCS_EN_BIT];
      end
      if (set_st) begin
        ev_st_reg <= 1'b1;
      end else if (i_pci_clr_st ||
                   (lw_pmcs && i_lbus.wdata[`PPE_PMCS_ST_BIT])) begin
        ev_st_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration: serial load or local host writes

  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sup_reg <= 4'h0;
      state_change_irq_enable_reg <= 1'b0;
      psc_rst_reg <= 1'b0;
      i2e_reg <= 1'b0;
      load_en_reg <= 1'b0;
    end else if (i_load_valid) begin
      sup_reg <= i_load_pmc[`PPE_PMC_SUP_LSB +: 4];
      psc_rst_reg <= i_load_misc2[`PPE_MISC2_RST_BIT];
      i2e_reg <= i_load_misc2[`PPE_MISC2_I2E_BIT];
      load_en_reg <= i_load_misc2[`PPE_MISC2_LOAD_BIT];
    end else if (lw) begin
      if (is_wr(i_lbus, `PPE_OFF_PMC)) begin
        sup_reg <= i_lbus.wdata[`PPE_PMC_SUP_LSB +: 4];
      end else if (is_wr(i_lbus, `PPE_OFF_INTCTL)) begin
        state_change_irq_enable_reg <= i_lbus.wdata[`PPE_INTCTL_PSC_BIT];
      end else if (is_wr(i_lbus, `PPE_OFF_MISC2)) begin
        psc_rst_reg <= i_lbus.wdata[`PPE_MISC2_RST_BIT];
        i2e_reg <= i_lbus.wdata[`PPE_MISC2_I2E_BIT];
        load_en_reg <= i_lbus.wdata[`PPE_MISC2_LOAD_BIT];
      end
    end
  end

  // state-change interrupt, sticky until software writes one to clear
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      psc_irq_reg <= 1'b0;
    end else if (state_change_irq_enable_reg && p_to_d3) begin
      psc_irq_reg <= 1'b1;
    end else if (state_change_irq_enable_reg && p_to_d0 && !psc_rst_reg) begin
      psc_irq_reg <= 1'b1;
    end else if (is_wr(i_lbus, `PPE_OFF_INTCTL) &&
                 i_lbus.wdata[`PPE_INTCTL_IRQ_BIT]) begin
      psc_irq_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake reset sequence

  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      seq_reg <= PPE_IDLE;
      cnt_reg <= '0;
    end else begin
      case (seq_reg)
        PPE_IDLE: begin
          if (p_to_d0 && psc_rst_reg) begin
            seq_reg <= PPE_RESET;
            cnt_reg <= '0;
          end
        end
        PPE_RESET: begin
          // parameter default sits inside the min..max window
          if (cnt_reg == LRST_LAST) begin
            seq_reg <= load_en_reg ? PPE_LOAD : PPE_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PPE_LOAD: begin
          if (i_load_valid) begin
            seq_reg <= PPE_IDLE;
          end
        end
        default: begin
          seq_reg <= PPE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_pm_event_out <= 1'b0;
      o_pm_event_oe <= 1'b0;
      o_local_irq_out <= 1'b0;
      o_local_irq_oe <= 1'b0;
      o_local_bus_reset_out_n <= 1'b0;
      o_int_reset <= 1'b0;
      o_load_req <= 1'b0;
      o_pm <= '0;
    end else begin
      // open drain: only ever pull low
      o_pm_event_out <= 1'b0;
      o_pm_event_oe <= ev_st_reg && ev_en_reg;
      o_local_irq_out <= 1'b0;
      o_local_irq_oe <= psc_irq_reg;
      o_local_bus_reset_out_n <= !int_rst;
      o_int_reset <= int_rst;
      o_load_req <= (seq_reg == PPE_LOAD);
      o_pm <= '{pstate: pstate_reg, ev_en: ev_en_reg, ev_st: ev_st_reg};
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_rdata <= '0;
    end else if (!i_lbus.rd) begin
      o_rdata <= '0;
    end else if (i_lbus.addr == `PPE_OFF_PMCS) begin
      o_rdata <= 32'(ev_st_reg) << `PPE_PMCS_ST_BIT |
                 32'(ev_en_reg) << `PPE_PMCS_EN_BIT |
                 32'(pstate_reg);
    end else if (i_lbus.addr == `PPE_OFF_PMC) begin
      o_rdata <= 32'(sup_reg) << `PPE_PMC_SUP_LSB;
    end else if (i_lbus.addr == `PPE_OFF_INTCTL) begin
      o_rdata <= 32'(psc_irq_reg) << `PPE_INTCTL_IRQ_BIT |
                 32'(state_change_irq_enable_reg);
    end else if (i_lbus.addr == `PPE_OFF_MISC2) begin
      o_rdata <= 32'(load_en_reg) << `PPE_MISC2_LOAD_BIT |
                 32'(i2e_reg) << `PPE_MISC2_I2E_BIT |
                 32'(psc_rst_reg);
    end else begin
      o_rdata <= '0;
    end
  end

endmodule

// ### verification/ppe_event_asserts.sv
`timescale 1ns/1ps
module ppe_event_asserts #(
  parameter int LRST_CYC = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_pci_ps_wr,
  input wire logic [1:0] i_pci_ps_wdata,
  input wire logic i_load_valid,
  input wire logic o_pm_event_out,
  input wire logic o_pm_event_oe,
  input wire logic o_local_irq_out,
  input wire logic o_local_irq_oe,
  input wire logic o_local_bus_reset_out_n,
  input wire logic o_int_reset,
  input wire logic o_load_req,
  input wire ppe_pkg::ppe_pm_t o_pm
);
  import ppe_pkg::*;
  logic [15:0] hi_cnt;
  // pulse too long for a repetition, so count it
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hi_cnt <= 16'h0;
    end else begin
      hi_cnt <= o_int_reset ? hi_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  AST_EV_ON: assert property (
    (o_pm.ev_en && o_pm.ev_st) [*3] |-> o_pm_event_oe
  ) else $error("event pin not asserted");
  AST_EV_OFF: assert property (
    (!o_pm.ev_en || !o_pm.ev_st) [*3] |-> !o_pm_event_oe
  ) else $error("event pin not released");
  AST_OD_LOW: assert property (
    !o_pm_event_out && !o_local_irq_out
  ) else $error("open drain pin driven high");
  AST_RST_OUT: assert property (
    o_int_reset |-> !o_local_bus_reset_out_n
  ) else $error("local reset not asserted");
  AST_RST_LEN: assert property (
    $fell(o_int_reset) |-> hi_cnt == LRST_CYC
  ) else $error("reset pulse length wrong");
  AST_RST_CAUSE: assert property (
    $rose(o_int_reset) |->
      $past(i_pci_ps_wr, 2) && $past(i_pci_ps_wdata, 2) == 2'h0
  ) else $error("reset without wake write");
  AST_LOAD_HOLD: assert property (
    o_load_req && !i_load_valid && !$past(i_load_valid) |=> o_load_req
  ) else $error("reload request dropped early");
  AST_IRQ_CAUSE: assert property (
    $rose(o_local_irq_oe) |-> $past(i_pci_ps_wr, 2)
  ) else $error("local irq without state write");
endmodule
bind ppe_event_top ppe_event_asserts #(.LRST_CYC(LRST_CYC)) i_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pci_ps_wr(i_pci_ps_wr),
  .i_pci_ps_wdata(i_pci_ps_wdata), .i_load_valid(i_load_valid),
  .o_pm_event_out(o_pm_event_out), .o_pm_event_oe(o_pm_event_oe),
  .o_local_irq_out(o_local_irq_out), .o_local_irq_oe(o_local_irq_oe),
  .o_local_bus_reset_out_n(o_local_bus_reset_out_n),
  .o_int_reset(o_int_reset), .o_load_req(o_load_req), .o_pm(o_pm)
);

// ### verification/ppe_host_model.sv
`timescale 1ns/1ps
module ppe_host_model (
  input wire logic i_sys_clk,
  input wire logic i_pme_oe,
  output logic o_pme_n,
  output logic o_ps_wr,
  output logic [1:0] o_ps_wdata,
  output logic o_clr_st,
  output logic o_en_wr,
  output logic o_en_wdata
);
  // shared line idles high through its pull-up
  assign o_pme_n = !i_pme_oe;
  initial begin
    o_ps_wr = 1'b0;
    o_ps_wdata = 2'h0;
    o_clr_st = 1'b0;
    o_en_wr = 1'b0;
    o_en_wdata = 1'b0;
  end
  task automatic ps(input logic [1:0] d);
    @(posedge i_sys_clk);
    o_ps_wr <= 1'b1;
    o_ps_wdata <= d;
    @(posedge i_sys_clk);
    o_ps_wr <= 1'b0;
    o_ps_wdata <= ~d;
  endtask
  task automatic clr();
    @(posedge i_sys_clk);
    o_clr_st <= 1'b1;
    @(posedge i_sys_clk);
    o_clr_st <= 1'b0;
  endtask
  task automatic en(input logic b);
    @(posedge i_sys_clk);
    o_en_wr <= 1'b1;
    o_en_wdata <= b;
    @(posedge i_sys_clk);
    o_en_wr <= 1'b0;
    o_en_wdata <= ~b;
  endtask
  // answer a wake request by moving the card to D0
  task automatic wake();
    int n;
    n = 0;
    while (o_pme_n && n < 50) begin
      @(posedge i_sys_clk);
      n++;
    end
    ps(2'h0);
  endtask
endmodule

// ### verification/ppe_event_top_tb.sv
`timescale 1ns/1ps
module ppe_event_top_tb;
  import ppe_pkg::*;
  localparam int LRST = 8;
  logic clk, rstn, ldv, irqn, ps_wr, clr, enw, en_d, pme_n;
  logic ev_out, ev_oe, iq_out, iq_oe, lrst_n, irst, ldreq;
  logic [1:0] ps_d;
  logic [31:0] lpmc, lmisc, rdata;
  ppe_bus_t lb;
  ppe_pm_t pm;
  int miscompares, check_count, n;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ppe_host_model i_ppe_host_model (
    .i_sys_clk(clk), .i_pme_oe(ev_oe), .o_pme_n(pme_n), .o_ps_wr(ps_wr),
    .o_ps_wdata(ps_d), .o_clr_st(clr), .o_en_wr(enw), .o_en_wdata(en_d)
  );
  ppe_event_top #(.LRST_CYC(LRST)) i_ppe_event_top (
    .i_sys_clk(clk), .i_rstn(rstn), .i_lbus(lb), .i_pci_ps_wr(ps_wr),
    .i_pci_ps_wdata(ps_d), .i_pci_clr_st(clr), .i_pci_en_wr(enw),
    .i_pci_en_wdata(en_d), .i_load_valid(ldv), .i_load_pmc(lpmc),
    .i_load_misc2(lmisc), .i_local_irq_n(irqn), .o_rdata(rdata),
    .o_pm_event_out(ev_out), .o_pm_event_oe(ev_oe),
    .o_local_irq_out(iq_out), .o_local_irq_oe(iq_oe),
    .o_local_bus_reset_out_n(lrst_n), .o_int_reset(irst),
    .o_load_req(ldreq), .o_pm(pm)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    lb <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    lb <= '{a, ~d, 1'b0, 1'b0};
  endtask
  task automatic br(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    lb <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    lb.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk(lrst_n, 1'b1);
    bw(4'h1, 32'hFFFF_FFFF);
    br(4'h1, 32'h0);
    br(4'h0, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_local();
    bw(4'h4, 32'h4800_0000);
    bw(4'h0, 32'h0000_0003);
    cyc(3);
    chk(pm, 4'hD);
    chk(ev_oe, 1'b0);
    bw(4'h0, 32'h0000_8100);
    cyc(3);
    chk(ev_oe, 1'b1);
    chk(pme_n, 1'b0);
    chk(ev_out, 1'b0);
    i_ppe_host_model.clr();
    cyc(3);
    chk(ev_oe, 1'b0);
    bw(4'h0, 32'h0000_0003);
    i_ppe_host_model.en(1'b1);
    cyc(3);
    chk(ev_oe, 1'b1);
    i_ppe_host_model.en(1'b0);
    cyc(3);
    chk(ev_oe, 1'b0);
    i_ppe_host_model.clr();
    $display("local event test done");
  endtask
  task automatic t_pci_irq();
    bw(4'hC, 32'h0);
    bw(4'h8, 32'h1);
    i_ppe_host_model.ps(2'h0);
    cyc(3);
    chk(iq_oe, 1'b1);
    chk(iq_out, 1'b0);
    chk(pm.pstate, 2'h0);
    chk(lrst_n, 1'b1);
    bw(4'h8, 32'h0001_0001);
    cyc(2);
    chk(iq_oe, 1'b0);
    i_ppe_host_model.ps(2'h3);
    cyc(3);
    chk(iq_oe, 1'b1);
    chk(pm.pstate, 2'h3);
    bw(4'h8, 32'h0001_0000);
    $display("pci irq test done");
  endtask
  task automatic t_wake();
    bw(4'hC, 32'h5);
    i_ppe_host_model.ps(2'h0);
    cyc(2);
    chk(irst, 1'b1);
    chk(lrst_n, 1'b0);
    n = 0;
    while (!lrst_n && n < 100) begin
      cyc(1);
      n++;
    end
    // first low cycle was seen before the loop started counting
    chk(n, LRST - 1);
    cyc(1);
    chk(ldreq, 1'b1);
    @(posedge clk);
    ldv <= 1'b1;
    lpmc <= 32'h4800_0000;
    lmisc <= 32'h2;
    @(posedge clk);
    ldv <= 1'b0;
    lpmc <= 32'hB7FF_FFFF;
    lmisc <= 32'hFFFF_FFFD;
    cyc(2);
    chk(ldreq, 1'b0);
    br(4'hC, 32'h2);
    chk(pm.pstate, 2'h0);
    $display("wake reset test done");
  endtask
  task automatic t_irq();
    bw(4'h0, 32'h0000_0103);
    i_ppe_host_model.clr();
    cyc(3);
    chk(ev_oe, 1'b0);
    @(posedge clk);
    irqn <= 1'b0;
    cyc(7);
    chk(ev_oe, 1'b1);
    chk(pm.ev_st, 1'b1);
    @(posedge clk);
    irqn <= 1'b1;
    i_ppe_host_model.wake();
    cyc(3);
    chk(pm.pstate, 2'h0);
    $display("irq event test done");
  endtask
  initial begin
    rstn = 1'b0;
    lb = '0;
    ldv = 1'b0;
    lpmc = 32'h0;
    lmisc = 32'h0;
    irqn = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    cyc(4);
    t_reset();
    t_local();
    t_pci_irq();
    t_wake();
    t_irq();
    end_sim();
  end
  // whole run is little more than a hundred cycles
  initial begin
    #20000;
    miscompares++;
    $display("Error %0t watchdog expired", $time);
    end_sim();
  end
endmodule
